// ===== bench/mrst_link_chk.sv
// Checker on the link between controller and device.
// Assumes nominal termination stays enabled in every run that uses it.
`timescale 1ns/1ps
module mrst_link_chk (
	input wire logic                          link_clk, // Link clock
	input wire logic                          reset_n,  // Async reset, active low
	input wire logic [2:0]                    cmd,      // Command code
	input wire logic [mrst_pkg::MR_AW-1:0]    ba,       // Register select
	input wire logic [mrst_pkg::MR_WIDTH-1:0] addr,     // Register value
	input wire logic                          cke,      // Clock enable
	input wire logic                          odt       // Termination control
);
	int                            mod_cnt;
	int                            upd_cnt;
	int                            mrs_idx;
	logic [mrst_pkg::MR_WIDTH-1:0] last_val [8];
	logic [mrst_pkg::MR_WIDTH-1:0] slow_mask;
	logic                          is_mrs;
	assign is_mrs = (cmd == mrst_pkg::CMD_MRS);
	always_comb begin
		case (ba)
			mrst_pkg::MR_SEL_MR3: slow_mask = mrst_pkg::MR3_SLOW_MASK;
			mrst_pkg::MR_SEL_MR4: slow_mask = mrst_pkg::MR4_SLOW_MASK;
			mrst_pkg::MR_SEL_MR5: slow_mask = mrst_pkg::MR5_SLOW_MASK;
			mrst_pkg::MR_SEL_MR6: slow_mask = mrst_pkg::MR6_SLOW_MASK;
			default: slow_mask = '0;
		endcase
	end
	// Change seen against the last value sent; reset value taken as zero
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			mod_cnt <= 0;
			upd_cnt <= 0;
			mrs_idx <= 0;
			last_val <= '{default: '0};
		end else if (is_mrs) begin
			mod_cnt <= mrst_pkg::TMOD_TCK - 1;
			upd_cnt <= (((addr ^ last_val[ba]) & slow_mask) != '0) ? mrst_pkg::TUPD_TCK - 1 : 0;
			mrs_idx <= (mrs_idx < 7) ? mrs_idx + 1 : 7;
			last_val[ba] <= addr;
		end else begin
			mod_cnt <= (mod_cnt > 0) ? mod_cnt - 1 : 0;
			upd_cnt <= (upd_cnt > 0) ? upd_cnt - 1 : 0;
		end
	end
	default clocking cb @(posedge link_clk); endclocking
	default disable iff (!reset_n);
	a_mrs_spacing: assert property (is_mrs |=> (!is_mrs)[*7])
		else $error("register writes closer than the minimum spacing");
	a_mod_wait: assert property ((cmd == mrst_pkg::CMD_ZQCL || cmd == mrst_pkg::CMD_OTHER) |-> mod_cnt == 0)
		else $error("command issued before update delay ran out");
	a_slow_wait: assert property (is_mrs |-> upd_cnt == 0)
		else $error("register write during functional update");
	a_init_order: assert property (is_mrs && mrs_idx < 7 |-> ba == mrst_pkg::INIT_ORDER[mrs_idx*3 +: 3])
		else $error("initial register writes out of order");
	a_zq_after: assert property (cmd == mrst_pkg::CMD_ZQCL |-> mrs_idx == 7 && $past(cmd) == mrst_pkg::CMD_DES)
		else $error("calibration not after all writes with deselect");
	a_mrs_idle: assert property (is_mrs |-> cke && !odt)
		else $error("register write with clock disabled or termination on");
	a_odt_rise: assert property ($rose(odt) |-> mod_cnt == 0)
		else $error("termination raised inside update delay");
	a_cke_hold: assert property ($rose(cke) |=> cke[*8])
		else $error("clock enable dropped during initialisation");
endmodule // mrst_link_chk

// ===== bench/test_mode_register_set_timing.sv
// Bench: both link ends joined, driven through the controller register port.
// Assumes the controller makes the link clock from clk.
`timescale 1ns/1ps
module test_mode_register_set_timing;
	logic        clk;
	logic        reset_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic [31:0] rdata;
	logic [31:0] got;
	logic        banks_idle;
	logic [97:0] mr_flat;
	logic [6:0]  mr_written;
	logic        updating;
	int          bad_count;
	int          n_compared;
	int          cycles;
	mrst_link_if mrst_link_if_i ();
	mrst_ctrl mrst_ctrl_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .banks_idle(banks_idle), .link(mrst_link_if_i));
	mrst_device mrst_device_i (.link(mrst_link_if_i), .reset_n(reset_n), .mr_flat(mr_flat),
		.mr_written(mr_written), .updating(updating));
	mrst_link_chk mrst_link_chk_i (.link_clk(mrst_link_if_i.link_clk), .reset_n(reset_n),
		.cmd(mrst_link_if_i.cmd), .ba(mrst_link_if_i.ba), .addr(mrst_link_if_i.addr),
		.cke(mrst_link_if_i.cke), .odt(mrst_link_if_i.odt));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] mr_val(input int n);
		return {18'h0, 14'h2000 | 14'(n << 9) | ((n == 6) ? 14'h0055 : 14'h0)};
	endfunction
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		got = rdata;
		@(posedge clk);
	endtask
	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		{reset_n, addr, wdata, wr, rd, got, bad_count, n_compared, cycles} = '0;
		banks_idle = 1'b1;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int n = 0; n < 7; n++) wr_reg(mrst_pkg::ADDR_MRBASE + 8'(4 * n), mr_val(n));
		wr_reg(mrst_pkg::ADDR_CTRL, 32'h0000_002c);
		repeat (100) @(posedge clk);
		check({25'h0, mr_written}, 32'h0);
		wr_reg(mrst_pkg::ADDR_CTRL, 32'h0000_0005);
		for (int i = 0; i < 1000 && got[5] !== 1'b1; i++) rd_reg(mrst_pkg::ADDR_STAT);
		repeat (100) @(posedge clk);
		for (int n = 0; n < 7; n++) check({18'h0, mr_flat[n*14 +: 14]}, mr_val(n));
		check({25'h0, mr_written}, 32'h0000_007f);
		check({31'h0, updating}, 32'h0);
		rd_reg(mrst_pkg::ADDR_STAT);
		check(got & 32'h0000_00f0, 32'h0000_00f0);
		rd_reg(8'h3c);
		check(got, 32'h0);
		// Busy banks must hold the rewrite back
		banks_idle <= 1'b0;
		wr_reg(mrst_pkg::ADDR_MRBASE + 8'h08, 32'h0000_1234);
		wr_reg(mrst_pkg::ADDR_CTRL, 32'h0000_002c);
		repeat (200) @(posedge clk);
		check({18'h0, mr_flat[28 +: 14]}, mr_val(2));
		banks_idle <= 1'b1;
		repeat (200) @(posedge clk);
		check({18'h0, mr_flat[28 +: 14]}, 32'h0000_1234);
		wr_reg(mrst_pkg::ADDR_CTRL, 32'h0000_0006);
		repeat (200) @(posedge clk);
		check({31'h0, mrst_link_if_i.odt}, 32'h1);
		wrap_up();
	end
endmodule // test_mode_register_set_timing

// ===== verilog/mrst_ctrl.sv
// Controller end: issues MRS sequences with tMRD/tMOD spacing, drives the link clock.
// Assumes a register port: addr, wdata, wr, rd; read data the cycle after rd.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module mrst_ctrl (
	input  wire logic        clk,        // 20 MHz system clock
	input  wire logic        reset_n,    // Async reset, active low
	input  wire logic [7:0]  addr,       // Register address
	input  wire logic [31:0] wdata,      // Write data
	input  wire logic        wr,         // Write strobe
	input  wire logic        rd,         // Read strobe
	output logic      [31:0] rdata,      // Read data
	input  wire logic        banks_idle, // All banks precharged, bursts done
	mrst_link_if.ctrl        link        // Command link
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_INIT = 4'b0010,
		S_WAIT = 4'b0100,
		S_ZQ   = 4'b1000
	} mrst_state_t;

	typedef struct packed {
		mrst_state_t                                        state;
		logic [mrst_pkg::MR_COUNT*mrst_pkg::MR_WIDTH-1:0]   shadow;
		logic [2:0]                                         step;
		logic                                               init_done;
		logic                                               rtt_nom;
		logic                                               single_pend;
		logic [mrst_pkg::MR_AW-1:0]                         single_sel;
		logic [mrst_pkg::CNT_W-1:0]                         mrd_cnt;
		logic [mrst_pkg::CNT_W-1:0]                         mod_cnt;
		logic [$clog2(mrst_pkg::LINK_DIV)-1:0]              div;
		logic                                               lclk;
		logic [2:0]                                         cmd;
		logic [mrst_pkg::MR_AW-1:0]                         ba;
		logic [mrst_pkg::MR_WIDTH-1:0]                      maddr;
		logic                                               cke;
		logic                                               odt;
		logic                                               want_odt;
		logic                                               start;
		logic [31:0]                                        rdata;
	} mrst_ctrl_t;
	mrst_ctrl_t st, next_st;

	logic                             link_edge;
	logic                             can_issue;
	logic [mrst_pkg::MR_AW-1:0]       sel;
	logic [mrst_pkg::MR_WIDTH-1:0]    val;
	logic [mrst_pkg::MR_WIDTH-1:0]    slow_mask;
	logic [mrst_pkg::MR_AW-1:0]       mr_idx;

	always_comb begin
		next_st   = st;
		link_edge = 1'b0;
		can_issue = 1'b0;
		sel       = '0;
		val       = '0;
		slow_mask = '0;
		// Image window starts at 0x10, so word index is offset from 4
		mr_idx    = addr[4:2] - 3'h4;
		next_st.rdata = '0;

		// Register port
		if (wr) begin
			if (addr == mrst_pkg::ADDR_CTRL) begin
				next_st.start    = wdata[0];
				next_st.want_odt = wdata[1];
				next_st.rtt_nom  = wdata[2];
				if (wdata[3] && st.init_done) begin
					next_st.single_pend = 1'b1;
					next_st.single_sel  = wdata[6:4];
				end
			end else if (addr >= mrst_pkg::ADDR_MRBASE && addr < mrst_pkg::ADDR_MRBASE + 8'h1c) begin
				// Full register image kept so every field is redriven
				next_st.shadow[mr_idx * mrst_pkg::MR_WIDTH +: mrst_pkg::MR_WIDTH] =
					wdata[mrst_pkg::MR_WIDTH-1:0];
			end
		end
		if (rd) begin
			if (addr == mrst_pkg::ADDR_CTRL)
				next_st.rdata = {25'h0, st.single_sel, st.single_pend, st.rtt_nom, st.want_odt, st.start};
			else if (addr == mrst_pkg::ADDR_STAT)
				next_st.rdata = {24'h0, st.mod_cnt == '0, st.mrd_cnt == '0, st.init_done, st.cke, st.state};
			else if (addr >= mrst_pkg::ADDR_MRBASE && addr < mrst_pkg::ADDR_MRBASE + 8'h1c)
				next_st.rdata = {18'h0, st.shadow[mr_idx * mrst_pkg::MR_WIDTH +: mrst_pkg::MR_WIDTH]};
		end

		// Link clock divider; commands change on the falling link edge
		if (st.div == $clog2(mrst_pkg::LINK_DIV)'(mrst_pkg::LINK_DIV - 1)) begin
			next_st.div  = '0;
			next_st.lclk = ~st.lclk;
			link_edge    = st.lclk;
		end else begin
			next_st.div = st.div + 1'b1;
		end

		if (link_edge) begin
			next_st.cmd = mrst_pkg::CMD_DES;
			if (st.mrd_cnt != '0)
				next_st.mrd_cnt = st.mrd_cnt - 1'b1;
			if (st.mod_cnt != '0)
				next_st.mod_cnt = st.mod_cnt - 1'b1;
			// With rtt_nom set, termination on only once tMOD has run out
			next_st.odt = st.rtt_nom ? (st.want_odt && st.mod_cnt == '0 && st.state == mrst_state_t'(S_IDLE))
			                         : st.want_odt;
			can_issue = (st.mrd_cnt == '0) && !(st.rtt_nom && st.odt);
			case (st.state)
				S_IDLE: begin
					if (st.start && !st.init_done) begin
						next_st.cke   = 1'b1;
						next_st.step  = '0;
						next_st.state = S_INIT;
					end else if (st.single_pend && banks_idle && st.mod_cnt == '0 && can_issue) begin
						sel = st.single_sel;
						next_st.single_pend = 1'b0;
						next_st.state = S_WAIT;
					end
				end
				S_INIT: begin
					if (can_issue) begin
						sel = mrst_pkg::INIT_ORDER[st.step * mrst_pkg::MR_AW +: mrst_pkg::MR_AW];
						next_st.step = st.step + 1'b1;
						if (st.step == 3'h6)
							next_st.state = S_ZQ;
					end
				end
				S_ZQ: begin
					if (st.mod_cnt == '0) begin
						next_st.cmd       = mrst_pkg::CMD_ZQCL;
						next_st.init_done = 1'b1;
						next_st.start     = 1'b0;
						next_st.state     = S_IDLE;
					end
				end
				S_WAIT: begin
					if (st.mod_cnt == '0)
						next_st.state = S_IDLE;
				end
				default: next_st.state = S_IDLE;
			endcase
		end
		if (link_edge && ((st.state == S_INIT && can_issue) || (st.state == S_IDLE && next_st.state == S_WAIT))) begin
			val = st.shadow[sel * mrst_pkg::MR_WIDTH +: mrst_pkg::MR_WIDTH];
			if (sel == mrst_pkg::MR_SEL_MR3) slow_mask = mrst_pkg::MR3_SLOW_MASK;
			else if (sel == mrst_pkg::MR_SEL_MR4) slow_mask = mrst_pkg::MR4_SLOW_MASK;
			else if (sel == mrst_pkg::MR_SEL_MR5) slow_mask = mrst_pkg::MR5_SLOW_MASK;
			else if (sel == mrst_pkg::MR_SEL_MR6) slow_mask = mrst_pkg::MR6_SLOW_MASK;
			next_st.cmd   = mrst_pkg::CMD_MRS;
			next_st.ba    = sel;
			next_st.maddr = val;
			// Input-altering fields take the longer update wait in place of tMRD/tMOD
			if ((val & slow_mask) != (st.maddr & slow_mask) || st.ba != sel) begin
				next_st.mrd_cnt = (slow_mask != '0) ? mrst_pkg::CNT_W'(mrst_pkg::TUPD_TCK)
				                                    : mrst_pkg::CNT_W'(mrst_pkg::TMRD_TCK);
				next_st.mod_cnt = (slow_mask != '0) ? mrst_pkg::CNT_W'(mrst_pkg::TUPD_TCK)
				                                    : mrst_pkg::CNT_W'(mrst_pkg::TMOD_TCK);
			end else begin
				next_st.mrd_cnt = mrst_pkg::CNT_W'(mrst_pkg::TMRD_TCK);
				next_st.mod_cnt = mrst_pkg::CNT_W'(mrst_pkg::TMOD_TCK);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			st <= '{state: S_IDLE, default: '0};
		else
			st <= next_st;
	end

	assign rdata         = st.rdata;
	assign link.link_clk = st.lclk;
	assign link.cmd      = st.cmd;
	assign link.ba       = st.ba;
	assign link.addr     = st.maddr;
	assign link.cke      = st.cke;
	assign link.odt      = st.odt;
endmodule // mrst_ctrl

// ===== verilog/mrst_device.sv
// Device end: mode registers loaded by MRS on the link clock.
// Assumes the controller keeps the spacing and idle conditions.
`timescale 1ns/1ps
module mrst_device (
	mrst_link_if.dev                                           link,        // Command link
	input  wire logic                                          reset_n,     // Async reset, active low
	output logic [mrst_pkg::MR_COUNT*mrst_pkg::MR_WIDTH-1:0]   mr_flat,     // Applied registers
	output logic [mrst_pkg::MR_COUNT-1:0]                      mr_written,  // Written since reset
	output logic                                               updating     // Update in progress
);
	typedef struct packed {
		logic [mrst_pkg::MR_COUNT*mrst_pkg::MR_WIDTH-1:0] pend;
		logic [mrst_pkg::MR_COUNT*mrst_pkg::MR_WIDTH-1:0] mr;
		logic [mrst_pkg::MR_COUNT-1:0]                     wr;
		logic [mrst_pkg::CNT_W-1:0]                        upd;
	} mrst_dev_t;
	mrst_dev_t st, next_st;

	always_comb begin
		next_st = st;
		if (st.upd != '0) begin
			next_st.upd = st.upd - 1'b1;
			if (st.upd == mrst_pkg::CNT_W'(1))
				next_st.mr = st.pend;
		end
		if (link.cke && link.cmd == mrst_pkg::CMD_MRS && int'(link.ba) < mrst_pkg::MR_COUNT) begin
			// Whole register replaced; array state is untouched here
			next_st.pend[link.ba*mrst_pkg::MR_WIDTH +: mrst_pkg::MR_WIDTH] = link.addr;
			next_st.wr[link.ba] = 1'b1;
			next_st.upd = mrst_pkg::CNT_W'(mrst_pkg::TMOD_TCK);
		end
	end

	always_ff @(posedge link.link_clk or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign mr_flat    = st.mr;
	assign mr_written = st.wr;
	assign updating   = (st.upd != '0);
endmodule // mrst_device

// ===== verilog/mrst_link_if.sv
// Command link between controller and device.
// Assumes the controller generates link_clk.
`timescale 1ns/1ps
interface mrst_link_if;
	logic                             link_clk;  // Link clock from controller
	logic [2:0]                       cmd;       // Command code
	logic [mrst_pkg::MR_AW-1:0]       ba;        // Register select
	logic [mrst_pkg::MR_WIDTH-1:0]    addr;      // Register value
	logic                             cke;       // Clock enable
	logic                             odt;       // Termination control
	modport ctrl (output link_clk, output cmd, output ba, output addr, output cke, output odt);
	modport dev  (input link_clk, input cmd, input ba, input addr, input cke, input odt);
endinterface

// ===== verilog/mrst_pkg.sv
// Constants, command codes and timing for the mode-register-set link.
// Assumes a controller on clk (20 MHz) and a device clocked by the link clock it drives.
package mrst_pkg;
	localparam int          MR_COUNT   = 7;
	localparam int          MR_WIDTH   = 14;
	localparam int          MR_AW      = 3;
	localparam int          LINK_DIV   = 2;              // Link clock = clk / (2*LINK_DIV)
	localparam int          TMRD_TCK   = 8;              // Link cycles
	localparam int          TMOD_TCK   = 24;             // Link cycles
	localparam int          TUPD_TCK   = 64;             // Functional update of input-altering settings
	localparam int          CNT_W      = 8;
	localparam logic [2:0]  CMD_DES    = 3'h0;
	localparam logic [2:0]  CMD_MRS    = 3'h1;
	localparam logic [2:0]  CMD_ZQCL   = 3'h2;
	localparam logic [2:0]  CMD_OTHER  = 3'h3;
	localparam logic [MR_AW*MR_COUNT-1:0] INIT_ORDER = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
	localparam logic [MR_AW-1:0] MR_SEL_MR3 = 3'h3;
	localparam logic [MR_AW-1:0] MR_SEL_MR4 = 3'h4;
	localparam logic [MR_AW-1:0] MR_SEL_MR5 = 3'h5;
	localparam logic [MR_AW-1:0] MR_SEL_MR6 = 3'h6;
	localparam logic [MR_WIDTH-1:0] MR3_SLOW_MASK = 14'h0018; // Gear-down, per-device addressing
	localparam logic [MR_WIDTH-1:0] MR4_SLOW_MASK = 14'h01c2; // Max power saving, CS latency
	localparam logic [MR_WIDTH-1:0] MR5_SLOW_MASK = 14'h0007; // Parity latency
	localparam logic [MR_WIDTH-1:0] MR6_SLOW_MASK = 14'h00ff; // VrefDQ value, range, mode
	localparam logic [7:0]  ADDR_CTRL  = 8'h00;
	localparam logic [7:0]  ADDR_STAT  = 8'h04;
	localparam logic [7:0]  ADDR_WDATA = 8'h08;
	localparam logic [7:0]  ADDR_MRBASE = 8'h10;
endpackage
